// ---- hdl/fcsi_consts.svh ----
// Constants of the flash command and status host controller
// Operation
// - Erase timer low allows more blocks; high allows only erase suspend.
// - Unlock is AAh to 555h then 55h to 2AAh, address bits 0 to 11.
// - After read/reset from erase mode the host waits 10 us before reading.
// - Unlock then 90h at 555h enters identification mode.
// - Byte program is unlock, A0h at 555h, then address and data.
`ifndef FCSI_CONSTS_SVH
`define FCSI_CONSTS_SVH
`define FCSI_UNLOCK1_ADDR 12'h0555
`define FCSI_UNLOCK2_ADDR 12'h02AA
`define FCSI_UNLOCK1_DATA 8'hAA
`define FCSI_UNLOCK2_DATA 8'h55
`define FCSI_CMD_RESET 8'hF0
`define FCSI_CMD_IDENT 8'h90
`define FCSI_CMD_PROGRAM 8'hA0
`define FCSI_CMD_SUSPEND 8'hB0
`define FCSI_BIT_POLL 7
`define FCSI_BIT_TOGGLE 6
`define FCSI_BIT_ERROR 5
`define FCSI_BIT_TIMER 3
`define FCSI_BIT_EBTOG 2
`define FCSI_REG_CTRL 4'h0
`define FCSI_REG_ADDR 4'h1
`define FCSI_REG_DATA 4'h2
`define FCSI_REG_STAT 4'h3
`define FCSI_REG_RDATA 4'h4
`define FCSI_ADDR_W 20
// Ctrl opcodes written to the control register
`define FCSI_OP_READ 3'h1
`define FCSI_OP_RESET 3'h2
`define FCSI_OP_IDENT 3'h3
`define FCSI_OP_PROG 3'h4
`define FCSI_OP_SUSP 3'h5
// Pin phase lengths in clocks at 5 ns: setup 20 ns, strobe 50 ns, hold 20 ns, read 100 ns
`define FCSI_T_SETUP_NS 20
`define FCSI_T_STROBE_NS 50
`define FCSI_T_READ_NS 100
`define FCSI_CLK_NS 5
`define FCSI_CYC(ns) (((ns) + `FCSI_CLK_NS - 1) / `FCSI_CLK_NS)
`define FCSI_T_WAIT_US 10
`define FCSI_WAIT_CYC (`FCSI_T_WAIT_US * 1000 / `FCSI_CLK_NS)
`endif

// ---- hdl/fcsi_pkg.sv ----
// Types of the flash command and status host controller
package fcsi_pkg;
    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] data;
    } fcsi_cycle_t;
    typedef struct packed {
        logic chip_en_n;
        logic out_en_n;
        logic wr_en_n;
    } fcsi_strobes_t;
    typedef enum logic [3:0] {
        FCSI_IDLE, FCSI_WSETUP, FCSI_WSTROBE, FCSI_WHOLD, FCSI_NEXT,
        FCSI_RSETUP, FCSI_RWAIT, FCSI_RDONE, FCSI_SETTLE
    } fcsi_state_t;
endpackage

// ---- hdl/fcsi_host.sv ----
// Host controller issuing command cycles and reading status of a byte-wide flash
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "fcsi_consts.svh"
module fcsi_host import fcsi_pkg::*; #(
    parameter int WAIT_CYC = `FCSI_WAIT_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [19:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input wire logic [7:0] flash_dq_in,
    output logic flash_chip_en_n,
    output logic flash_out_en_n,
    output logic flash_wr_en_n
);
    localparam int SETUP_CYC = `FCSI_CYC(`FCSI_T_SETUP_NS);
    localparam int STROBE_CYC = `FCSI_CYC(`FCSI_T_STROBE_NS);
    localparam int READ_CYC = `FCSI_CYC(`FCSI_T_READ_NS);

    fcsi_state_t state_r;
    fcsi_cycle_t seq_r [0:3];
    fcsi_cycle_t cur_r;
    fcsi_strobes_t strb_r;
    logic [2:0] seq_len_r;
    logic [2:0] seq_idx_r;
    logic [19:0] tgt_addr_r;
    logic [7:0] tgt_data_r;
    logic [7:0] rd_byte_r;
    logic [7:0] prev_byte_r;
    logic [31:0] cnt_r;
    logic busy_r;
    logic in_erase_r;
    logic rd_after_r;
    logic [7:0] dq_s1_r, dq_s2_r, dq_s3_r;
    logic dq_oe_n_r;

    // One command write cycle: 12-bit address zero-extended, with its data byte
    function automatic fcsi_cycle_t wcyc(input logic [11:0] a, input logic [7:0] d);
        fcsi_cycle_t c;
        c.addr = {8'h00, a};
        c.data = d;
        return c;
    endfunction

    // Bit differs between two reads: this is how toggle polling is judged
    function automatic logic flips(input logic [7:0] a, input logic [7:0] b, input int bitn);
        return a[bitn] ^ b[bitn];
    endfunction

    // Three-stage data sampler; only stage 2 and 3 are used by logic
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            dq_s1_r <= 8'h00;
            dq_s2_r <= 8'h00;
            dq_s3_r <= 8'h00;
        end else if (clk_en) begin
            dq_s1_r <= flash_dq_in;
            dq_s2_r <= dq_s1_r;
            dq_s3_r <= dq_s2_r;
        end
    end

    // Command sequencer: builds the write cycles then walks the pins
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_r <= FCSI_IDLE;
            seq_len_r <= 3'h0;
            seq_idx_r <= 3'h0;
            cnt_r <= 32'h0000_0000;
            busy_r <= 1'b0;
            in_erase_r <= 1'b0;
            rd_after_r <= 1'b0;
            rd_byte_r <= 8'h00;
            prev_byte_r <= 8'h00;
            tgt_addr_r <= 20'h0_0000;
            tgt_data_r <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                seq_r[i] <= '0;
            end
        end else if (clk_en) begin
            unique case (state_r)
                FCSI_IDLE: begin
                    if (reg_wr && reg_addr == `FCSI_REG_ADDR) begin
                        tgt_addr_r <= reg_wdata[19:0];
                    end
                    if (reg_wr && reg_addr == `FCSI_REG_DATA) begin
                        tgt_data_r <= reg_wdata[7:0];
                    end
                    if (reg_wr && reg_addr == `FCSI_REG_CTRL) begin
                        busy_r <= 1'b1;
                        seq_idx_r <= 3'h0;
                        rd_after_r <= 1'b0;
                        state_r <= FCSI_NEXT;
                        unique case (reg_wdata[2:0])
                            `FCSI_OP_READ: begin
                                seq_len_r <= 3'h0;
                                state_r <= FCSI_RSETUP;
                            end
                            `FCSI_OP_RESET: begin
                                // Erase mode ignores reset; settle time still spent
                                seq_r[0] <= wcyc(12'h000, `FCSI_CMD_RESET);
                                seq_len_r <= 3'h1;
                            end
                            `FCSI_OP_IDENT: begin
                                seq_r[0] <= wcyc(`FCSI_UNLOCK1_ADDR, `FCSI_UNLOCK1_DATA);
                                seq_r[1] <= wcyc(`FCSI_UNLOCK2_ADDR, `FCSI_UNLOCK2_DATA);
                                seq_r[2] <= wcyc(`FCSI_UNLOCK1_ADDR, `FCSI_CMD_IDENT);
                                seq_len_r <= 3'h3;
                                rd_after_r <= 1'b1;
                            end
                            `FCSI_OP_PROG: begin
                                seq_r[0] <= wcyc(`FCSI_UNLOCK1_ADDR, `FCSI_UNLOCK1_DATA);
                                seq_r[1] <= wcyc(`FCSI_UNLOCK2_ADDR, `FCSI_UNLOCK2_DATA);
                                seq_r[2] <= wcyc(`FCSI_UNLOCK1_ADDR, `FCSI_CMD_PROGRAM);
                                seq_r[3] <= '{addr: tgt_addr_r, data: tgt_data_r};
                                seq_len_r <= 3'h4;
                            end
                            `FCSI_OP_SUSP: begin
                                // Only command the device takes once erase has begun
                                seq_r[0] <= wcyc(12'h000, `FCSI_CMD_SUSPEND);
                                seq_len_r <= 3'h1;
                                in_erase_r <= 1'b1;
                            end
                            default: begin
                                busy_r <= 1'b0;
                                state_r <= FCSI_IDLE;
                            end
                        endcase
                    end
                end
                FCSI_NEXT: begin
                    cnt_r <= 32'h0000_0000;
                    if (seq_idx_r == seq_len_r) begin
                        if (seq_r[0].data == `FCSI_CMD_RESET && seq_len_r == 3'h1 && in_erase_r) begin
                            state_r <= FCSI_SETTLE;
                        end else if (rd_after_r) begin
                            state_r <= FCSI_RSETUP;
                        end else begin
                            busy_r <= 1'b0;
                            state_r <= FCSI_IDLE;
                        end
                    end else begin
                        cur_r <= seq_r[seq_idx_r[1:0]];
                        state_r <= FCSI_WSETUP;
                    end
                end
                FCSI_WSETUP: begin
                    // Address settles before the falling strobe latches it
                    cnt_r <= cnt_r + 32'h0000_0001;
                    if (cnt_r == 32'(SETUP_CYC - 1)) begin
                        cnt_r <= 32'h0000_0000;
                        state_r <= FCSI_WSTROBE;
                    end
                end
                FCSI_WSTROBE: begin
                    cnt_r <= cnt_r + 32'h0000_0001;
                    if (cnt_r == 32'(STROBE_CYC - 1)) begin
                        cnt_r <= 32'h0000_0000;
                        state_r <= FCSI_WHOLD;
                    end
                end
                FCSI_WHOLD: begin
                    cnt_r <= cnt_r + 32'h0000_0001;
                    if (cnt_r == 32'(SETUP_CYC - 1)) begin
                        seq_idx_r <= seq_idx_r + 3'h1;
                        state_r <= FCSI_NEXT;
                    end
                end
                FCSI_RSETUP: begin
                    cnt_r <= 32'h0000_0000;
                    state_r <= FCSI_RWAIT;
                end
                FCSI_RWAIT: begin
                    // Wait access time plus sampler depth before taking the byte
                    cnt_r <= cnt_r + 32'h0000_0001;
                    if (cnt_r == 32'(READ_CYC + 2)) begin
                        state_r <= FCSI_RDONE;
                    end
                end
                FCSI_RDONE: begin
                    if (dq_s2_r == dq_s3_r) begin
                        prev_byte_r <= rd_byte_r;
                        rd_byte_r <= dq_s3_r;
                        busy_r <= 1'b0;
                        state_r <= FCSI_IDLE;
                    end
                end
                FCSI_SETTLE: begin
                    cnt_r <= cnt_r + 32'h0000_0001;
                    if (cnt_r == 32'(WAIT_CYC - 1)) begin
                        in_erase_r <= 1'b0;
                        busy_r <= 1'b0;
                        state_r <= FCSI_IDLE;
                    end
                end
                default: state_r <= FCSI_IDLE;
            endcase
        end
    end

    // Pin drive: strobes low only in their phase, data driven only on writes
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            flash_addr <= 20'h0_0000;
            flash_dq_out <= 8'h00;
            dq_oe_n_r <= 1'b1;
            strb_r <= '{chip_en_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1};
        end else if (clk_en) begin
            strb_r <= '{chip_en_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1};
            dq_oe_n_r <= 1'b1;
            if (state_r == FCSI_WSETUP || state_r == FCSI_WSTROBE || state_r == FCSI_WHOLD) begin
                flash_addr <= cur_r.addr;
                flash_dq_out <= cur_r.data;
                dq_oe_n_r <= 1'b0;
                strb_r.chip_en_n <= 1'b0;
                strb_r.wr_en_n <= (state_r != FCSI_WSETUP || cnt_r != 32'(SETUP_CYC - 1)) &&
                                  (state_r != FCSI_WSTROBE || cnt_r == 32'(STROBE_CYC - 1));
            end else if (state_r == FCSI_RSETUP || state_r == FCSI_RWAIT) begin
                flash_addr <= tgt_addr_r;
                strb_r.chip_en_n <= 1'b0;
                strb_r.out_en_n <= 1'b0;
            end
        end
    end
    assign flash_chip_en_n = strb_r.chip_en_n;
    assign flash_out_en_n = strb_r.out_en_n;
    assign flash_wr_en_n = strb_r.wr_en_n;
    assign flash_dq_oe_n = dq_oe_n_r;

    // Register read port; status decode uses last two reads for toggle bits
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    `FCSI_REG_ADDR: reg_rdata <= {12'h000, tgt_addr_r};
                    `FCSI_REG_DATA: reg_rdata <= {24'h00_0000, tgt_data_r};
                    `FCSI_REG_RDATA: reg_rdata <= {24'h00_0000, rd_byte_r};
                    `FCSI_REG_STAT: reg_rdata <= {22'h00_0000, in_erase_r, busy_r,
                        flips(rd_byte_r, prev_byte_r, `FCSI_BIT_TOGGLE),
                        flips(rd_byte_r, prev_byte_r, `FCSI_BIT_EBTOG),
                        rd_byte_r[`FCSI_BIT_ERROR],
                        rd_byte_r[`FCSI_BIT_POLL],
                        rd_byte_r[`FCSI_BIT_TIMER],
                        rd_byte_r[`FCSI_BIT_EBTOG],
                        1'b0, 1'b0};
                    default: reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ---- verification/fcsi_host_checker.sv ----
// Assertions on the pins and register port of the flash host controller
`timescale 1ns/1ps
module fcsi_host_checker import fcsi_pkg::*; #(
    parameter int WAIT_CYC = 2000
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [19:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_dq_oe_n,
    input wire logic flash_chip_en_n,
    input wire logic flash_out_en_n,
    input wire logic flash_wr_en_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Write strobe only inside select, host on the bus, output enable off
    wr_framed_a: assert property (!flash_wr_en_n |-> !flash_chip_en_n && !flash_dq_oe_n && flash_out_en_n)
        else $error("write strobe outside its frame");
    // Host lets go of the bus whenever the flash may drive it
    rd_release_a: assert property (!flash_out_en_n |-> flash_dq_oe_n && !flash_chip_en_n && flash_wr_en_n)
        else $error("bus contention on read");
    // Select and address settle before the strobe falls
    wr_setup_a: assert property ($fell(flash_wr_en_n) |-> !$past(flash_chip_en_n, 3) && $stable(flash_addr))
        else $error("write setup too short");
    wr_width_a: assert property ($fell(flash_wr_en_n) |-> ##9 !flash_wr_en_n ##1 flash_wr_en_n)
        else $error("write strobe width wrong");
    // Flash latches on either edge, so nothing may move under the strobe
    wr_stable_a: assert property (!flash_wr_en_n && !$past(flash_wr_en_n) |-> $stable({flash_addr, flash_dq_out}))
        else $error("address or data moved under strobe");
    wr_hold_a: assert property ($rose(flash_wr_en_n) |->
        (!flash_chip_en_n && $stable({flash_addr, flash_dq_out}))[*3]) else $error("write hold too short");
    // Identification reads decode the address, so it stays put
    rd_hold_a: assert property ($fell(flash_out_en_n) |=> (!flash_out_en_n && $stable(flash_addr))[*8])
        else $error("read address moved");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    reset_quiet_a: assert property (disable iff (1'b0) !reset_n |=> flash_chip_en_n && flash_wr_en_n && flash_dq_oe_n)
        else $error("pins active in reset");
    cover property ($fell(flash_wr_en_n));
    cover property ($fell(flash_out_en_n));
    cover property (reg_rd ##1 reg_rdata[5]);
endmodule
bind fcsi_host fcsi_host_checker #(.WAIT_CYC(WAIT_CYC)) chk (.clock(clock), .reset_n(reset_n), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_chip_en_n(flash_chip_en_n), .flash_out_en_n(flash_out_en_n), .flash_wr_en_n(flash_wr_en_n));

// ---- verification/fcsi_flash_model.sv ----
// Behavioural byte-wide flash: command decoder, small array and status bits
`timescale 1ns/1ps
module fcsi_flash_model #(
    parameter logic [7:0] MAKER_ID = 8'h5C, // Arbitrary value
    parameter logic [7:0] PART_ID = 8'hC5, // Arbitrary value
    parameter logic [6:0] PROT_BLOCK = 7'h01,
    parameter int PROG_NS = 1000
) (
    input wire logic [19:0] addr,
    input wire logic [7:0] dq_host,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic [7:0] dq_dev
);
    logic [7:0] mem [256];
    logic [7:0] pend, last;
    logic [19:0] lat_a;
    logic [1:0] step;
    logic ident, armed, err, tog;
    realtime done_t;
    // Erased array in read mode; only 256 bytes, upper address bits alias
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        {step, ident, armed, err, tog, pend, last, dq_dev} = '0;
        done_t = 0;
    end
    // Address taken at the later falling edge of select or strobe
    always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) lat_a = addr;
    // Commands on the rising strobe edge; only the low 12 address bits count
    always @(posedge we_n) begin
        if (armed) begin
            err = |(dq_host & ~mem[lat_a[7:0]]);
            mem[lat_a[7:0]] = mem[lat_a[7:0]] & dq_host;
            pend = dq_host;
            done_t = $realtime + (err ? 0 : PROG_NS);
            armed = 1'b0;
        end else if (dq_host == 8'hF0) begin
            {step, ident, err} = '0;
        end else if (step == 0 && lat_a[11:0] == 12'h555 && dq_host == 8'hAA) begin
            step = 1;
        end else if (step == 1 && lat_a[11:0] == 12'h2AA && dq_host == 8'h55) begin
            step = 2;
        end else begin
            ident = step == 2 && lat_a[11:0] == 12'h555 && dq_host == 8'h90;
            armed = step == 2 && lat_a[11:0] == 12'h555 && dq_host == 8'hA0;
            step = 0;
        end
    end
    // Released bus shows the inverse of the last byte so stale data never passes
    always @(oe_n) begin
        if (oe_n) begin
            dq_dev = ~last;
        end else begin
            // Short access delay so the address pin has settled before it is decoded
            #1;
            if ($realtime < done_t || err) begin
                tog = ~tog;
                last = {~pend[7], tog, err, 5'h04};
            end else if (ident && addr[1:0] == 2'h0) last = MAKER_ID;
            else if (ident && addr[1:0] == 2'h1) last = PART_ID;
            else if (ident && addr[1:0] == 2'h2 && !addr[6]) last = {7'h00, addr[19:13] == PROT_BLOCK};
            else last = mem[addr[7:0]];
            dq_dev = last;
        end
    end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench: flash host controller against a behavioural flash
`timescale 1ns/1ps
`include "fcsi_consts.svh"
module tb;
    logic clock, reset_n, clk_en, reg_wr, reg_rd, dq_oe_n, ce_n, oe_n, we_n;
    // Short settle wait so the erase-mode reset stays cheap to simulate
    localparam int SETTLE_CYC = 20;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, s, b;
    logic [19:0] flash_addr;
    logic [7:0] dq_out, dq_dev;
    int errors, comparisons, n, n1;
    // Shared data wire: host while its enable is low, flash otherwise
    wire [7:0] dq_bus = !dq_oe_n ? dq_out : dq_dev;
    fcsi_host #(.WAIT_CYC(SETTLE_CYC)) DUT (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
        .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_bus), .flash_chip_en_n(ce_n),
        .flash_out_en_n(oe_n), .flash_wr_en_n(we_n));
    fcsi_flash_model flash (.addr(flash_addr), .dq_host(dq_bus), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .dq_dev(dq_dev));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        // One idle edge so back-to-back writes never drive the strobe twice at once
        @(posedge clock);
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        // Taken at the next edge, before the port clears it again
        @(posedge clock);
        d = reg_rdata;
    endtask
    // Start an operation and poll busy; a hang ends the run
    task automatic op(input logic [2:0] code, output int cnt);
        wr(`FCSI_REG_CTRL, {29'h0, code});
        for (cnt = 0; cnt < 4000; cnt++) begin
            rd(`FCSI_REG_STAT, s);
            if (s[8] === 1'b0) return;
        end
        errors++;
        print_verdict();
    endtask
    task automatic t_reset();
        rd(`FCSI_REG_STAT, s);
        check("idle busy", s & 32'h0000_0100, 32'h0000_0000);
        rd(4'hF, s);
        check("unmapped read", s, 32'h0000_0000);
    endtask
    // A command written while the enable is low must be lost
    task automatic t_freeze();
        clk_en <= 1'b0;
        wr(`FCSI_REG_CTRL, {29'h0, `FCSI_OP_RESET});
        clk_en <= 1'b1;
        rd(`FCSI_REG_STAT, s);
        check("frozen write dropped", s & 32'h0000_0100, 32'h0000_0000);
    endtask
    // Every identification selector, then back to the array
    task automatic t_ident();
        logic [19:0] ad [4] = '{20'h0_0000, 20'h0_0001, 20'h0_2002, 20'h0_4002};
        logic [7:0] ex [4] = '{8'h5C, 8'hC5, 8'h01, 8'h00};
        for (int i = 0; i < 4; i++) begin
            wr(`FCSI_REG_ADDR, {12'h000, ad[i]});
            op(`FCSI_OP_IDENT, n);
            rd(`FCSI_REG_RDATA, b);
            check("ident byte", b, {24'h00_0000, ex[i]});
        end
        wr(`FCSI_REG_ADDR, 32'h0000_0005);
        op(`FCSI_OP_RESET, n);
        op(`FCSI_OP_READ, n);
        rd(`FCSI_REG_RDATA, b);
        check("array after reset", b, 32'h0000_00FF);
    endtask
    // Program, watch status while busy, then the stored byte
    task automatic t_program();
        wr(`FCSI_REG_ADDR, 32'h0000_0010);
        wr(`FCSI_REG_DATA, 32'h0000_005A);
        op(`FCSI_OP_PROG, n);
        op(`FCSI_OP_READ, n);
        op(`FCSI_OP_READ, n);
        rd(`FCSI_REG_STAT, s);
        check("busy status", s & 32'h0000_00F4, 32'h0000_0094);
        b = 32'h0;
        for (int i = 0; i < 40 && b !== 32'h0000_005A; i++) begin
            op(`FCSI_OP_READ, n);
            rd(`FCSI_REG_RDATA, b);
        end
        check("programmed byte", b, 32'h0000_005A);
        op(`FCSI_OP_READ, n);
        rd(`FCSI_REG_STAT, s);
        check("steady toggles", s & 32'h0000_00C0, 32'h0000_0000);
    endtask
    // Writing a one over a zero fails until a reset clears it
    task automatic t_error();
        wr(`FCSI_REG_DATA, 32'h0000_00FF);
        op(`FCSI_OP_PROG, n);
        op(`FCSI_OP_READ, n);
        rd(`FCSI_REG_STAT, s);
        check("error flag", s & 32'h0000_0020, 32'h0000_0020);
        op(`FCSI_OP_RESET, n);
        op(`FCSI_OP_READ, n);
        rd(`FCSI_REG_RDATA, b);
        check("byte after reset", b, 32'h0000_005A);
        rd(`FCSI_REG_STAT, s);
        check("error cleared", s & 32'h0000_0020, 32'h0000_0000);
    endtask
    // Reset after suspend must add the settle wait
    task automatic t_suspend();
        op(`FCSI_OP_RESET, n1);
        op(`FCSI_OP_SUSP, n);
        op(`FCSI_OP_RESET, n);
        // Each status poll takes two clocks, so the settle wait adds half its length in polls
        check("settle polls", n - n1, SETTLE_CYC / 2);
    endtask
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        clk_en = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        errors = 0;
        comparisons = 0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_freeze();
        t_ident();
        t_program();
        t_error();
        t_suspend();
        print_verdict();
    end
endmodule
